/* File: asq_pkg.sv */
`default_nettype none
package asq_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Frame geometry, counted in serial-clock cycles
  localparam int unsigned CNT_BITS = 4;
  localparam logic [3:0] CONV_LAST = 4'hf;
  localparam logic [3:0] TRACK_CYCLES = 4'h3;
  localparam logic [3:0] LEAD_ZEROS = 4'h4;
  localparam logic [3:0] CTL_LAST = 4'h7;
  localparam logic [3:0] RESULT_TOP = 4'hf;
  ////////////////////////////////////////////////////////////////////////////
  // Control word layout
  localparam int unsigned CTL_BITS = 8;
  localparam int unsigned ADDR_MSB = 5;
  localparam int unsigned ADDR_LSB = 3;
  localparam int unsigned ADDR_BITS = 3;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // Converter data
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned AIN_BITS = 16;
  localparam int unsigned CODE_BITS = 12;
  localparam int unsigned CODE_SHIFT = 4;
  localparam logic [16:0] HALF_LSB = 17'h00008;
  localparam logic [11:0] CODE_MAX = 12'hfff;
  localparam logic [11:0] CODE_RESET = 12'h000;
  ////////////////////////////////////////////////////////////////////////////
  // Publisher of quantised codes toward the link side
  typedef enum logic [0:0] {
    PUB_LOAD,
    PUB_WAIT
  } asq_pub_e;
  typedef logic [NUM_CH-1:0][CODE_BITS-1:0] asq_bank_t;
  typedef logic [NUM_CH-1:0][AIN_BITS-1:0] asq_ain_t;
endpackage
`default_nettype wire

/* File: asq_sync.sv */
`default_nettype none
module asq_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } asq_sync_s;

  asq_sync_s sync_reg;
  asq_sync_s sync_next;

  // First stage feeds only the second stage
  always_comb begin
    sync_next.s1 = d;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clk) begin
    sync_reg <= sync_next;
  end

  assign q = sync_reg.s2;
endmodule // asq_sync
`default_nettype wire

/* File: asq_quant.sv */
`default_nettype none
module asq_quant
  import asq_pkg::*;
(
  input wire asq_pkg::asq_ain_t ain,
  output asq_pkg::asq_bank_t code
);
  // Input is the fraction of the analog supply scaled by 65536
  function automatic logic [11:0] asq_to_code(input logic [15:0] v);
    logic [16:0] sum;
    sum = {1'b0, v} + HALF_LSB;
    // Half-step offset puts the first transition at supply/8192
    asq_to_code = sum[16] ? CODE_MAX : sum[15:4];
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign code[gi] = asq_to_code(ain[gi]);
    end
  endgenerate
endmodule // asq_quant
`default_nettype wire

/* File: asq_adc_sequencer.sv */
`default_nettype none
// Summary of operation
// - Track mode lasts the first three serial-clock cycles after chip select falls.
// - Hold and conversion take the next thirteen cycles while result bits shift out.
// - Result is unsigned straight binary, step supply/4096, first change at supply/8192.
// - Powered while chip select is low except from each 16th falling edge to the next first edge, powered down while it is high.
// - Continuous mode powers down from 16th falling edge to next first edge.
// - Each conversion is 16 cycles; conversions repeat while chip select stays low.
// - Falling edges 1-4 give zeros, edges 5-16 give twelve bits MSB first.
// - Serial output floats while chip select is high, driven while low.
// - Serial clock is ignored by the conversion while chip select is high; its edges still pick up the code bank.
// - Track again at falling edge N*16+1, hold again at falling edge N*16+4.
// - Chip select falling with clock high: track starts at next falling edge.
// - Chip select falling with clock low: track at once, counts as falling edge.
// - Chip select and clock falling together: track starts at that moment.
// - Control word is captured on the first eight rising edges of each conversion.
// - First conversion after power-up converts input zero without dummy cycles.
// - No start-up delay; full acquisition available in the first frame.
// - Control bits 7, 6, 2, 1 and 0 have no effect.
// - Control bits 5 to 3 pick the input for the next conversion.
// - Address decodes as binary index 0 to 7, zero by default.
module asq_adc_sequencer (
  input wire logic mclk,
  input wire logic reset,
  input wire asq_pkg::asq_ain_t analog_in,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  output logic track_mode,
  output logic powered_up
);
  import asq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Position within a conversion, from the count of rising edges passed
  function automatic logic asq_in_ctl(input logic [3:0] c);
    return c <= CTL_LAST;
  endfunction

  function automatic logic asq_is_commit(input logic [3:0] c);
    return c == CTL_LAST;
  endfunction

  function automatic logic asq_in_track(input logic [3:0] c);
    return c < TRACK_CYCLES;
  endfunction

  function automatic logic asq_is_hold(input logic [3:0] c);
    return c == TRACK_CYCLES;
  endfunction

  function automatic logic asq_in_lead(input logic [3:0] c);
    return c < LEAD_ZEROS;
  endfunction

  function automatic logic asq_is_last(input logic [3:0] c);
    return c == CONV_LAST;
  endfunction

  function automatic logic [3:0] asq_bit_of(input logic [3:0] c);
    return RESULT_TOP - c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // System clock side: quantise inputs and publish them across
  typedef struct packed {
    asq_pub_e st;
    logic req_tog;
    logic clr_chan;
    asq_bank_t bank;
  } asq_pub_s;

  localparam asq_pub_s PUB_RST = '{
    st: PUB_LOAD, req_tog: 1'b0, clr_chan: 1'b1, bank: '0
  };

  asq_pub_s pub_reg;
  asq_pub_s pub_next;
  asq_ain_t ain_sync;
  asq_bank_t codes;
  logic ack_sync;

  asq_sync #(.W(NUM_CH * AIN_BITS)) u_ain_sync (
    .clk(mclk),
    .d(analog_in),
    .q(ain_sync)
  );

  asq_quant u_quant (
    .ain(ain_sync),
    .code(codes)
  );

  // The bank is only changed while the link side has acknowledged it,
  // so the wide word is stable whenever the link side copies it
  always_comb begin
    pub_next = pub_reg;
    case (pub_reg.st)
      PUB_LOAD: begin
        pub_next.bank = codes;
        pub_next.req_tog = ~pub_reg.req_tog;
        pub_next.st = PUB_WAIT;
      end
      PUB_WAIT: begin
        if (ack_sync == pub_reg.req_tog) begin
          pub_next.clr_chan = 1'b0;
          pub_next.st = PUB_LOAD;
        end
      end
      default: pub_next.st = PUB_LOAD;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pub_reg <= PUB_RST;
    end else begin
      pub_reg <= pub_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side, rising edges: cycle count and control word
  typedef struct packed {
    logic [3:0] cnt;
    logic [7:0] ctl;
  } asq_seq_s;

  localparam asq_seq_s SEQ_RST = '{cnt: 4'h0, ctl: CTL_RESET};

  asq_seq_s seq_reg;
  asq_seq_s seq_next;
  logic [7:0] ctl_word;

  assign ctl_word = {seq_reg.ctl[6:0], din};

  always_comb begin
    seq_next = seq_reg;
    seq_next.cnt = seq_reg.cnt + 4'h1;
    if (asq_in_ctl(seq_reg.cnt)) begin
      seq_next.ctl = ctl_word;
    end
  end

  // Chip select high holds the sequence in reset, so stray clocks do nothing
  // and an abandoned conversion restarts at the next frame
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      seq_reg <= SEQ_RST;
    end else begin
      seq_reg <= seq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side, rising edges: state that outlives a frame
  typedef struct packed {
    logic seen_tog;
    logic [2:0] chan;
    asq_bank_t bank;
  } asq_keep_s;

  asq_keep_s keep_reg;
  asq_keep_s keep_next;
  logic req_sync;

  asq_sync #(.W(1)) u_req_sync (
    .clk(sclk),
    .d(pub_reg.req_tog),
    .q(req_sync)
  );

  asq_sync #(.W(1)) u_ack_sync (
    .clk(mclk),
    .d(keep_reg.seen_tog),
    .q(ack_sync)
  );

  logic clr_sync;

  asq_sync #(.W(1)) u_clr_sync (
    .clk(sclk),
    .d(pub_reg.clr_chan),
    .q(clr_sync)
  );

  always_comb begin
    keep_next = keep_reg;
    // Follows the request on every edge, so an unknown start settles at once
    keep_next.seen_tog = req_sync;
    if (req_sync != keep_reg.seen_tog) begin
      keep_next.bank = pub_reg.bank;
      if (pub_reg.clr_chan) begin
        keep_next.chan = CHAN_RESET;
      end
    end
    // Catches a first toggle that passed before the clock ran;
    // a frame opened inside this short window after reset may lose its address
    if (clr_sync && cs_n) begin
      keep_next.chan = CHAN_RESET;
    end
    // Only a complete eighth bit commits an address
    if (!cs_n && asq_is_commit(seq_reg.cnt)) begin
      keep_next.chan = ctl_word[ADDR_MSB:ADDR_LSB];
    end
  end

  // No frame reset here: the address must survive chip select going high
  always_ff @(posedge sclk) begin
    keep_reg <= keep_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side, falling edges: phase, power gap and serial output
  typedef struct packed {
    logic fell_seen;
    logic track;
    logic gap;
    logic dout;
    logic [11:0] result;
  } asq_out_s;

  localparam asq_out_s OUT_RST = '{
    fell_seen: 1'b0, track: 1'b0, gap: 1'b0, dout: 1'b0, result: CODE_RESET
  };

  asq_out_s out_reg;
  asq_out_s out_next;
  logic [3:0] bit_idx;
  logic low_at_fall_reg;

  assign bit_idx = asq_bit_of(seq_reg.cnt);

  always_comb begin
    out_next = out_reg;
    out_next.fell_seen = 1'b1;
    out_next.track = asq_in_track(seq_reg.cnt);
    out_next.gap = asq_is_last(seq_reg.cnt);
    if (asq_is_hold(seq_reg.cnt)) begin
      out_next.result = keep_reg.bank[keep_reg.chan];
    end
    if (asq_in_lead(seq_reg.cnt)) begin
      out_next.dout = 1'b0;
    end else begin
      out_next.dout = out_reg.result[bit_idx];
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_reg <= OUT_RST;
    end else begin
      out_reg <= out_next;
    end
  end

  // Clock level at the chip-select fall; a simultaneous fall reads as low
  always_ff @(negedge cs_n) begin
    low_at_fall_reg <= ~sclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs; enable and power follow chip select without waiting for a clock
  assign dout = out_reg.dout;
  assign dout_oe = ~cs_n;
  assign track_mode = ~cs_n & (out_reg.track | (~out_reg.fell_seen & low_at_fall_reg));
  assign powered_up = ~cs_n & ~out_reg.gap;
endmodule // asq_adc_sequencer
`default_nettype wire

/* File: asq_seq_sva.sv */
`default_nettype none
module asq_seq_sva
  import asq_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic track_mode,
  input wire logic powered_up
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] rise_cnt_reg;
  // Cleared by chip select like the frame counter, so it never drifts across frames
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) rise_cnt_reg <= 4'h0;
    else rise_cnt_reg <= rise_cnt_reg + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  float_idle_a: assert property (
    @(posedge mclk) disable iff (reset) cs_n |-> !dout_oe) else $error("enable while idle");
  drive_low_a: assert property (
    @(posedge mclk) disable iff (reset) !cs_n |-> dout_oe) else $error("no drive in frame");
  sleep_idle_a: assert property (
    @(posedge mclk) disable iff (reset) cs_n |-> !powered_up) else $error("awake while idle");
  track_idle_a: assert property (
    @(posedge mclk) disable iff (reset) cs_n |-> !track_mode) else $error("track while idle");
  zero_idle_a: assert property (
    @(posedge mclk) disable iff (reset) cs_n |-> !dout) else $error("data while idle");
  // Sampled before the rising edge: the count names the falling edge just passed
  track_phase_a: assert property (
    @(posedge sclk) disable iff (cs_n) track_mode == (rise_cnt_reg < TRACK_CYCLES))
    else $error("track phase wrong");
  lead_zero_a: assert property (
    @(posedge sclk) disable iff (cs_n) rise_cnt_reg < LEAD_ZEROS |-> !dout)
    else $error("leading bit not zero");
  power_gap_a: assert property (
    @(posedge sclk) disable iff (cs_n) powered_up == (rise_cnt_reg != CONV_LAST))
    else $error("power gap wrong");
  full_conv_c: cover property (@(posedge sclk) disable iff (cs_n) rise_cnt_reg == CONV_LAST);
  abandon_c: cover property (@(posedge cs_n) rise_cnt_reg != 4'h0);
  low_start_c: cover property (@(negedge cs_n) !sclk);
endmodule // asq_seq_sva
bind asq_adc_sequencer asq_seq_sva chk (.mclk(mclk), .reset(reset), .sclk(sclk),
  .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe), .track_mode(track_mode),
  .powered_up(powered_up));
`default_nettype wire

/* File: asq_host_model.sv */
`default_nettype none
module asq_host_model (
  output var logic sclk,
  output var logic cs_n,
  output var logic din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] word;
  event got;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Edges while deselected let the link side pick up the code bank
  task automatic idle(input int n);
    repeat (n) begin
      #6 sclk = 1'b0;
      #6 sclk = 1'b1;
      din = ~din;
    end
  endtask
  // A count short of whole words abandons the frame on purpose
  // Mode 1 lowers the clock before select, mode 2 together with it
  task automatic frame(input logic [15:0] w[$], input int n, input bit [1:0] lo);
    if (lo == 2'd1) sclk = 1'b0;
    #6 cs_n = 1'b0;
    if (lo == 2'd2) sclk = 1'b0;
    for (int k = 0; k < n; k++) begin
      #6 sclk = 1'b0;
      din = w[k/16][15-k%16];
      #6 sclk = 1'b1;
      word = {word[14:0], dout};
      if (k % 16 == 15) ->got;
    end
    #6 cs_n = 1'b1;
    din = ~din;
  endtask
endmodule // asq_host_model
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk;
  logic reset;
  asq_pkg::asq_ain_t ain;
  logic sclk, cs_n, din, dout, dout_oe, track_mode, powered_up;
  logic [15:0] exp_q[$];
  logic [2:0] ch;
  int fail_count, compares, seed;
  asq_adc_sequencer dut (.mclk(mclk), .reset(reset), .analog_in(ain), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe), .track_mode(track_mode),
    .powered_up(powered_up));
  asq_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Nearest step of supply/4096, first step at half a step, clipped at full scale
  function automatic logic [15:0] code_of(input logic [15:0] v);
    int c;
    c = (int'(v) * 32'sh2 + 32'sh10) / 32'sh20;
    if (c > 32'sh0fff) c = 32'sh0fff;
    return 16'(c);
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Only whole words are expected; the address sticks once its eighth rising edge passed
  task automatic run(input int n, input int cut, input bit [1:0] lo);
    logic [15:0] w[$];
    logic [15:0] x;
    int tot;
    tot = cut ? cut : 16 * n;
    for (int j = 0; j < n; j++) begin
      x = 16'($random(seed));
      x[13:11] = 3'(j);
      w.push_back(x);
      if (16 * j + 16 <= tot) exp_q.push_back(code_of(ain[ch]));
      if (16 * j + 8 <= tot) ch = x[13:11];
    end
    host.frame(w, tot, lo);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever begin
      @(host.got);
      check("result", host.word, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
    end
  end
  initial begin
    #20000;
    fail_count++;
    final_report();
  end
  initial begin
    seed = 32'h7db9;
    reset = 1'b1;
    ch = 3'h0;
    ain[0] = 16'h0007;
    ain[1] = 16'h0008;
    ain[2] = 16'hfff7;
    ain[3] = 16'hfff8;
    for (int i = 4; i < 8; i++) ain[i] = 16'($random(seed));
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    host.idle(40);
    run(9, 0, 2'd0);
    run(1, 7, 2'd0);
    run(2, 0, 2'd1);
    run(2, 20, 2'd0);
    run(1, 0, 2'd0);
    run(3, 0, 2'd2);
    #100;
    check("queue size", 16'(exp_q.size()), 16'h0000);
    final_report();
  end
endmodule // testbench
`default_nettype wire
